//--- eiop_pkg.sv
package eiop_pkg;
  localparam int EIOP_W = 8;
  localparam int EIOP_AW = 16;
  localparam logic [15:0] EIOP_ADDR_LATCH = 16'hffdb;
  localparam logic [15:0] EIOP_ADDR_DIR = 16'hffeb;
  localparam logic [15:0] EIOP_ADDR_MODE = 16'hffec;
  localparam logic [15:0] EIOP_ADDR_TMR = 16'hffed;
  localparam logic [7:0] EIOP_LATCH_RST = 8'h00;
  localparam logic [7:0] EIOP_DIR_RST = 8'h00;
  localparam logic [7:0] EIOP_DIR_READ = 8'hff;
  localparam logic [7:0] EIOP_ZERO = 8'h00;
  localparam int EIOP_TMR_PIN = 1;
  localparam int EIOP_MODE_HIZ = 0;
  localparam int EIOP_MODE_HOLD = 1;
  localparam int EIOP_TMR_EN_BIT = 0;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } eiop_drive_s;
endpackage : eiop_pkg

//--- eiop_port.sv
// Functional notes
// - Eight-bit data register holds output value for each pin.
// - Read of a pin with direction bit 1 returns its latched value.
// - Read of an input pin returns its synchronised pin level.
// - Each direction bit selects output (1) or input (0), except pin 1 under timer enable.
// - Reset clears the data register.
// - Reset clears the direction register, all pins inputs.
// - Direction register is write-only and reads as all ones.
// - Pins float in reset and standby, hold in sleep/watch.
// - Timer enable drives compare output on pin 1, ignoring direction.
`timescale 1ns/10ps
module eiop_port
  import eiop_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [EIOP_AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe,
  input wire logic timer_compare_out_a
);

  // Only pin 1 doubles as the timer compare output
  localparam logic [7:0] TMR_MASK = 8'h01 << EIOP_TMR_PIN;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic TMR_RST = 1'b0;

  // Software-visible state
  logic [7:0] port_output_latch_q, port_output_latch_d;
  logic [7:0] port_direction_select_q, port_direction_select_d;
  logic [1:0] mode_q, mode_d;
  logic tmr_q, tmr_d;

  // Read data is registered, so it stands for one cycle only
  logic [7:0] rdata_q, rdata_d;

  // Pin drive state, registered so the pins come straight from flops
  eiop_drive_s drv_q, drv_d;
  eiop_drive_s drv_run;
  logic [7:0] tmr_sel;
  logic standby;
  logic hold;

  // Two-stage synchronisers for the pins and the timer level
  logic [7:0] sync1_q, sync1_d;
  logic [7:0] sync2_q, sync2_d;
  logic tmr_s1_q, tmr_s1_d;
  logic tmr_s2_q, tmr_s2_d;

  // Decoded strobes
  logic wr_latch;
  logic wr_dir;
  logic wr_mode;
  logic wr_tmr;
  logic rd_latch;
  logic rd_dir;
  logic rd_mode;
  logic rd_tmr;

  // Full-width compare, so no alias of the port answers
  function automatic logic addr_hit(
    input logic [EIOP_AW-1:0] a,
    input logic [EIOP_AW-1:0] base
  );
    addr_hit = (a == base);
  endfunction : addr_hit

  // Per-pin choice between two sources under a select mask
  function automatic logic [7:0] bit_pick(
    input logic [7:0] sel,
    input logic [7:0] when_one,
    input logic [7:0] when_zero
  );
    bit_pick = (sel & when_one) | (~sel & when_zero);
  endfunction : bit_pick

  // Narrow control fields read back zero-extended
  function automatic logic [7:0] ctrl_word(input logic [1:0] field);
    ctrl_word = {6'h00, field};
  endfunction : ctrl_word

  // Pin drive before the standby and hold overrides
  function automatic eiop_drive_s pin_drive(
    input logic [7:0] latch,
    input logic [7:0] dir,
    input logic [7:0] shared,
    input logic level
  );
    eiop_drive_s d;
    d.o = bit_pick(shared, {8{level}}, latch);
    d.oe = dir | shared;
    pin_drive = d;
  endfunction : pin_drive

  // Bus decode
  always_comb begin
    wr_latch = wr & addr_hit(addr, EIOP_ADDR_LATCH);
    wr_dir = wr & addr_hit(addr, EIOP_ADDR_DIR);
    wr_mode = wr & addr_hit(addr, EIOP_ADDR_MODE);
    wr_tmr = wr & addr_hit(addr, EIOP_ADDR_TMR);
    rd_latch = rd & addr_hit(addr, EIOP_ADDR_LATCH);
    rd_dir = rd & addr_hit(addr, EIOP_ADDR_DIR);
    rd_mode = rd & addr_hit(addr, EIOP_ADDR_MODE);
    rd_tmr = rd & addr_hit(addr, EIOP_ADDR_TMR);
  end

  // Only the second stage is read, the first may be metastable
  always_comb begin
    sync1_d = pin_i;
    sync2_d = sync1_q;
    tmr_s1_d = timer_compare_out_a;
    tmr_s2_d = tmr_s1_q;
  end

  always_ff @(posedge core_clk) begin
    sync1_q <= sync1_d;
    sync2_q <= sync2_d;
    tmr_s1_q <= tmr_s1_d;
    tmr_s2_q <= tmr_s2_d;
  end

  // Data register
  always_comb begin
    port_output_latch_d = port_output_latch_q;
    if (wr_latch) begin
      port_output_latch_d = wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      port_output_latch_q <= EIOP_LATCH_RST;
    end else begin
      port_output_latch_q <= port_output_latch_d;
    end
  end

  // Direction register, one bit per pin
  always_comb begin
    port_direction_select_d = port_direction_select_q;
    if (wr_dir) begin
      port_direction_select_d = wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      port_direction_select_q <= EIOP_DIR_RST;
    end else begin
      port_direction_select_q <= port_direction_select_d;
    end
  end

  // Operating mode: standby floats the pins, hold freezes them
  always_comb begin
    mode_d = mode_q;
    if (wr_mode) begin
      mode_d = wdata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode_q <= MODE_RST;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Timer output enable for the shared pin
  always_comb begin
    tmr_d = tmr_q;
    if (wr_tmr) begin
      tmr_d = wdata[EIOP_TMR_EN_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tmr_q <= TMR_RST;
    end else begin
      tmr_q <= tmr_d;
    end
  end

  // Read path; an input pin reads its level from two cycles back
  always_comb begin
    rdata_d = EIOP_ZERO;
    if (rd_latch) begin
      rdata_d = bit_pick(port_direction_select_q,
                         port_output_latch_q,
                         sync2_q);
    end else if (rd_dir) begin
      rdata_d = EIOP_DIR_READ;
    end else if (rd_mode) begin
      rdata_d = ctrl_word(mode_q);
    end else if (rd_tmr) begin
      rdata_d = ctrl_word({1'b0, tmr_q});
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_q <= EIOP_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Pin drive; standby wins over hold for the enables
  always_comb begin
    standby = mode_q[EIOP_MODE_HIZ];
    hold = mode_q[EIOP_MODE_HOLD];
    tmr_sel = tmr_q ? TMR_MASK : EIOP_ZERO;
    drv_run = pin_drive(port_output_latch_q,
                        port_direction_select_q,
                        tmr_sel,
                        tmr_s2_q);
    drv_d = drv_run;
    if (hold) begin
      drv_d = drv_q;
    end
    if (standby) begin
      drv_d.oe = EIOP_ZERO;
    end
  end

  // Reset floats every pin
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      drv_q <= '0;
    end else begin
      drv_q <= drv_d;
    end
  end

  assign rdata = rdata_q;
  assign pin_o = drv_q.o;
  assign pin_oe = drv_q.oe;

endmodule : eiop_port

//--- eiop_checker.sv
`timescale 1ns/10ps
module eiop_checker
  import eiop_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe
);
  logic [1:0] mode_sh_q;
  logic tmr_sh_q;
  logic quiet;
  // Bus-side shadow of mode and timer enable, so checks skip overrides
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode_sh_q <= 2'h0;
      tmr_sh_q <= 1'b0;
    end else begin
      if (wr && addr == EIOP_ADDR_MODE) begin
        mode_sh_q <= wdata[1:0];
      end
      if (wr && addr == EIOP_ADDR_TMR) begin
        tmr_sh_q <= wdata[EIOP_TMR_EN_BIT];
      end
    end
  end
  assign quiet = (mode_sh_q == 2'h0) && !tmr_sh_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_rst_clear: assert property ($rose(rstn) |-> (pin_o | pin_oe) == 8'h00)
    else $error("pins not clear");
  a_dir_ones: assert property (rd && addr == EIOP_ADDR_DIR |=> rdata == 8'hff)
    else $error("dir read");
  a_dir_pins: assert property (wr && addr == EIOP_ADDR_DIR && quiet
    |=> ##1 pin_oe == $past(wdata, 2))
    else $error("dir to pins");
  a_out_latch: assert property (rd && addr == EIOP_ADDR_LATCH && quiet
    |=> (rdata & pin_oe) == (pin_o & pin_oe))
    else $error("out read");
  a_latch_drive: assert property (wr && addr == EIOP_ADDR_LATCH && quiet
    |=> ##1 pin_o == $past(wdata, 2))
    else $error("latch to pins");
  a_standby_float: assert property (wr && addr == EIOP_ADDR_MODE && wdata[EIOP_MODE_HIZ]
    |=> ##1 pin_oe == 8'h00)
    else $error("standby drive");
  a_timer_pin: assert property (wr && addr == EIOP_ADDR_TMR && wdata[EIOP_TMR_EN_BIT]
    && mode_sh_q == 2'h0 |=> ##1 pin_oe[EIOP_TMR_PIN])
    else $error("timer pin");
endmodule : eiop_checker
bind eiop_port eiop_checker u_chk (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .pin_o(pin_o), .pin_oe(pin_oe));

//--- eiop_board.sv
`timescale 1ns/10ps
module eiop_board (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext,
  output logic [7:0] pin_i
);
  assign pin_i = (pin_o & pin_oe) | (ext & ~pin_oe);
endmodule : eiop_board

//--- eight_bit_io_port_tb.sv
`timescale 1ns/10ps
module eight_bit_io_port_tb;
  logic core_clk = 0, rstn = 0, wr = 0, rd = 0, tmr = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, ext = 8'h00, rdata, pin_i, pin_o, pin_oe;
  int bad_count = 0, num_checks = 0;
  always #20 core_clk = ~core_clk;
  eiop_port uut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .timer_compare_out_a(tmr));
  eiop_board brd (.pin_o(pin_o), .pin_oe(pin_oe), .ext(ext), .pin_i(pin_i));
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task bus(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge core_clk);
    {wr, rd, addr, wdata} <= {w, !w, a, d};
    @(posedge core_clk);
    {wr, rd} <= 2'b00;
    #1 if (!w) cmp(rdata, exp);
  endtask : bus
  task settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  task t_reset;
    bus(1'b0, 16'hffeb, 8'h00, 8'hff);
    cmp(pin_oe, 8'h00);
    cmp(pin_o, 8'h00);
    bus(1'b0, 16'hffdb, 8'h00, 8'h00);
  endtask : t_reset
  task t_mixed;
    @(posedge core_clk);
    ext <= 8'h3c;
    bus(1'b1, 16'hffdb, 8'ha5, 8'h00);
    bus(1'b1, 16'hffeb, 8'h0f, 8'h00);
    settle(3);
    cmp(pin_oe, 8'h0f);
    cmp(pin_o, 8'ha5);
    bus(1'b0, 16'hffdb, 8'h00, 8'h35);
    bus(1'b0, 16'hffeb, 8'h00, 8'hff);
  endtask : t_mixed
  task t_modes;
    bus(1'b1, 16'hffec, 8'h01, 8'h00);
    settle(3);
    cmp(pin_oe, 8'h00);
    bus(1'b0, 16'hffec, 8'h00, 8'h01);
    bus(1'b1, 16'hffec, 8'h00, 8'h00);
    settle(3);
    cmp(pin_oe, 8'h0f);
    bus(1'b1, 16'hffec, 8'h02, 8'h00);
    bus(1'b1, 16'hffdb, 8'h5a, 8'h00);
    settle(3);
    cmp(pin_o, 8'ha5);
    cmp(pin_oe, 8'h0f);
    bus(1'b1, 16'hffec, 8'h00, 8'h00);
    settle(3);
    cmp(pin_o, 8'h5a);
  endtask : t_modes
  task t_timer;
    bus(1'b1, 16'hffeb, 8'h0d, 8'h00);
    bus(1'b1, 16'hffed, 8'h01, 8'h00);
    settle(4);
    cmp(pin_oe, 8'h0f);
    cmp(pin_o, 8'h58);
    bus(1'b0, 16'hffdb, 8'h00, 8'h38);
    bus(1'b0, 16'hffed, 8'h00, 8'h01);
    @(posedge core_clk);
    tmr <= 1'b1;
    settle(4);
    cmp(pin_o, 8'h5a);
    bus(1'b1, 16'hffed, 8'h00, 8'h00);
    settle(3);
    cmp(pin_oe, 8'h0d);
  endtask : t_timer
  task t_rerun;
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    cmp(pin_oe, 8'h00);
    cmp(pin_o, 8'h00);
    bus(1'b0, 16'hffdb, 8'h00, 8'h3c);
    bus(1'b0, 16'hffeb, 8'h00, 8'hff);
  endtask : t_rerun
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset;
    t_mixed;
    t_modes;
    t_timer;
    t_rerun;
    test_done;
  end
endmodule : eight_bit_io_port_tb
